// [hdl/prog_port_regs.svh]
`ifndef PROG_PORT_REGS_SVH
`define PROG_PORT_REGS_SVH
`define IR_RESET_CHAIN   4'hc
`define IR_UNLOCK        4'h4
`define IR_COMMAND       4'h5
`define IR_PAGE_FILL     4'h6
`define IR_PAGE_DUMP     4'h7
`define IR_BYPASS        4'hf
`define IR_CAPTURE_VAL   4'h1
`define UNLOCK_KEY       16'ha370
`define UNLOCK_RESET     16'h0000
`define CMD_RESET        15'h0000
`define PORT_CLR_CLOCKS  2
`define RST_TIMEOUT_DEF  16
`define PB_WRITE_MAX     11
`define SER_POLL_B1      8'hf0
`define SER_POLL_B2      8'h00
`define SER_EFUSE_B1     8'h50
`define SER_EFUSE_B2     8'h08
`define SER_CAL_B1       8'h38
`define SER_OUT_BIT      5'd24
`endif

// [hdl/prog_port_pkg.sv]
package prog_port_pkg;
  typedef enum logic [3:0] {
    tlr, rti, sel_dr, cap_dr, sh_dr, ex1_dr, pau_dr, ex2_dr, upd_dr,
    sel_ir, cap_ir, sh_ir, ex1_ir, pau_ir, ex2_ir, upd_ir
  } tap_state_e;
  // request to the flash array, all on the test clock
  typedef struct packed {
    logic [14:0] cmd;       // applied command
    logic        exec;      // one-cycle execute clock
    logic        pb_write;  // page buffer byte write
    logic        pb_high;   // byte is high half of word
    logic [7:0]  pb_data;   // byte to write
    logic        pc_step;   // word pointer increment
  } flash_req_s;
endpackage : prog_port_pkg

// [hdl/prog_port.sv]
`timescale 1ns/100ps
`default_nettype none
`include "prog_port_regs.svh"
module prog_port
  import prog_port_pkg::*;
#(
  parameter int RST_TIMEOUT = `RST_TIMEOUT_DEF
)(
  // chip clock and power-on reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // test port pins
  input  wire logic        tck,
  input  wire logic        tms,
  input  wire logic        tdi,
  output logic             tdo_o,
  output logic             tdo_oe,
  // chip side
  input  wire logic        ext_reset_n,
  input  wire logic        port_enable_fuse,
  input  wire logic        port_disable_set,
  output logic             port_disable_bit,
  output logic             chip_reset,
  output logic             prog_mode,
  // flash array
  output flash_req_s       flash_req,
  input  wire logic [14:0] flash_result,
  input  wire logic [15:0] flash_word,
  input  wire logic        op_in_progress,
  // serial programming pins
  input  wire logic        sck,
  input  wire logic        mosi,
  input  wire logic [7:0]  ext_fuse,
  input  wire logic [7:0]  cal_byte,
  output logic             miso_o,
  output logic             miso_oe
);
  initial
  begin
    if (RST_TIMEOUT < 1) $error("RST_TIMEOUT must be at least one");
  end

  // tap next state
  function automatic tap_state_e tap_next(input tap_state_e s, input logic m);
    case (s)
      tlr:     tap_next = m ? tlr : rti;
      rti:     tap_next = m ? sel_dr : rti;
      sel_dr:  tap_next = m ? sel_ir : cap_dr;
      cap_dr:  tap_next = m ? ex1_dr : sh_dr;
      sh_dr:   tap_next = m ? ex1_dr : sh_dr;
      ex1_dr:  tap_next = m ? upd_dr : pau_dr;
      pau_dr:  tap_next = m ? ex2_dr : pau_dr;
      ex2_dr:  tap_next = m ? upd_dr : sh_dr;
      upd_dr:  tap_next = m ? sel_dr : rti;
      sel_ir:  tap_next = m ? tlr : cap_ir;
      cap_ir:  tap_next = m ? ex1_ir : sh_ir;
      sh_ir:   tap_next = m ? ex1_ir : sh_ir;
      ex1_ir:  tap_next = m ? upd_ir : pau_ir;
      pau_ir:  tap_next = m ? ex2_ir : pau_ir;
      ex2_ir:  tap_next = m ? upd_ir : sh_ir;
      upd_ir:  tap_next = m ? sel_dr : rti;
      default: tap_next = tlr;
    endcase
  endfunction : tap_next

  // chip clock domain: external reset sync and port disable bit
  logic       ext_rst_meta_ff;
  logic       ext_rst_low_ff;
  logic [1:0] clr_cnt_ff;
  logic       disable_ff;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ext_rst_meta_ff <= 1'b0;
      ext_rst_low_ff  <= 1'b0;
    end
    else
    begin
      ext_rst_meta_ff <= ~ext_reset_n;
      ext_rst_low_ff  <= ext_rst_meta_ff;
    end
  end

  // disable bit clears after two chip clocks of external reset
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      clr_cnt_ff <= 2'h0;
      disable_ff <= 1'b0;
    end
    else
    begin
      if (!ext_rst_low_ff)
        clr_cnt_ff <= 2'h0;
      else if (clr_cnt_ff != 2'(`PORT_CLR_CLOCKS))
        clr_cnt_ff <= clr_cnt_ff + 2'h1;
      if (ext_rst_low_ff && clr_cnt_ff == 2'(`PORT_CLR_CLOCKS - 1))
        disable_ff <= 1'b0;
      else if (port_disable_set && !ext_rst_low_ff)
        disable_ff <= 1'b1;
    end
  end
  assign port_disable_bit = disable_ff;

  // port enable crossing into test clock domain
  logic dis_meta_ff;
  logic dis_sync_ff;
  logic port_on;

  always_ff @(posedge tck or posedge rst)
  begin
    if (rst)
    begin
      dis_meta_ff <= 1'b1;
      dis_sync_ff <= 1'b1;
    end
    else
    begin
      dis_meta_ff <= disable_ff;
      dis_sync_ff <= dis_meta_ff;
    end
  end
  assign port_on = port_enable_fuse & ~dis_sync_ff;

  // tap controller, runs on test clock alone
  tap_state_e state_ff;
  tap_state_e prev_ff;

  always_ff @(posedge tck or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= tlr;
      prev_ff  <= tlr;
    end
    else
    begin
      state_ff <= port_on ? tap_next(state_ff, tms) : tlr;
      prev_ff  <= state_ff;
    end
  end

  // instruction register
  logic [3:0] ir_sh_ff;
  logic [3:0] ir_ff;

  always_ff @(posedge tck or posedge rst)
  begin
    if (rst)
    begin
      ir_sh_ff <= 4'h0;
      ir_ff    <= `IR_BYPASS;
    end
    else
    begin
      case (state_ff)
        tlr:     ir_ff <= `IR_BYPASS;
        cap_ir:  ir_sh_ff <= `IR_CAPTURE_VAL;
        sh_ir:   ir_sh_ff <= {tdi, ir_sh_ff[3:1]};
        upd_ir:  ir_ff <= ir_sh_ff;
        default: ir_sh_ff <= ir_sh_ff;
      endcase
    end
  end

  logic sel_chain;
  logic sel_unlock;
  logic sel_cmd;
  logic sel_fill;
  logic sel_dump;
  assign sel_chain  = ir_ff == `IR_RESET_CHAIN;
  assign sel_unlock = ir_ff == `IR_UNLOCK;
  assign sel_cmd    = ir_ff == `IR_COMMAND;
  assign sel_fill   = ir_ff == `IR_PAGE_FILL;
  assign sel_dump   = ir_ff == `IR_PAGE_DUMP;

  // reset chain, its output feeds reset unlatched
  logic chain_ff;
  logic bypass_ff;

  always_ff @(posedge tck or posedge rst)
  begin
    if (rst)
    begin
      chain_ff  <= 1'b0;
      bypass_ff <= 1'b0;
    end
    else if (state_ff == sh_dr)
    begin
      if (sel_chain)
        chain_ff <= tdi;
      bypass_ff <= tdi;
    end
  end

  // unlock register and programming mode
  logic [15:0] unlock_ff;
  logic        prog_ff;

  always_ff @(posedge tck or posedge rst)
  begin
    if (rst)
    begin
      unlock_ff <= `UNLOCK_RESET;
      prog_ff   <= 1'b0;
    end
    else if (sel_unlock)
    begin
      if (state_ff == sh_dr)
        unlock_ff <= {tdi, unlock_ff[15:1]};
      if (state_ff == upd_dr)
        prog_ff <= unlock_ff == `UNLOCK_KEY;
    end
  end
  assign prog_mode = prog_ff;

  // command register, page byte is its low byte
  logic        dump_high_ff;  // read half select, declared before the capture mux uses it
  logic [14:0] cmd_sh_ff;
  logic [14:0] cmd_ff;
  logic        cmd_upd;
  assign cmd_upd = sel_cmd && state_ff == upd_dr && prog_ff;

  always_ff @(posedge tck or posedge rst)
  begin
    if (rst)
    begin
      cmd_sh_ff <= `CMD_RESET;
      cmd_ff    <= `CMD_RESET;
    end
    else
    begin
      if (sel_cmd && state_ff == cap_dr)
        cmd_sh_ff <= flash_result;
      else if (sel_cmd && state_ff == sh_dr)
        cmd_sh_ff <= {tdi, cmd_sh_ff[14:1]};
      else if ((sel_fill || sel_dump) && state_ff == sh_dr)
        cmd_sh_ff[7:0] <= {tdi, cmd_sh_ff[7:1]};
      else if (sel_dump && state_ff == cap_dr)
        cmd_sh_ff[7:0] <= dump_high_ff ? flash_word[15:8] : flash_word[7:0];
      if (cmd_upd)
        cmd_ff <= cmd_sh_ff;
    end
  end

  // page load and read byte alternation
  logic       fill_high_ff;
  logic       fill_first_ff;
  logic [7:0] tmp_ff;
  logic       pb_pend_ff;
  logic       pb_hi_ff;
  logic       step_ff;
  logic       exec_ff;

  always_ff @(posedge tck or posedge rst)
  begin
    if (rst)
    begin
      fill_high_ff  <= 1'b0;
      fill_first_ff <= 1'b1;
      dump_high_ff  <= 1'b0;
      tmp_ff        <= 8'h00;
      pb_pend_ff    <= 1'b0;
      pb_hi_ff      <= 1'b0;
      step_ff       <= 1'b0;
    end
    else
    begin
      pb_pend_ff <= 1'b0;
      step_ff    <= 1'b0;
      if (state_ff == upd_ir)
      begin
        fill_high_ff  <= 1'b0;
        fill_first_ff <= 1'b1;
        dump_high_ff  <= 1'b0;
      end
      else if (sel_fill && state_ff == upd_dr && prog_ff)
      begin
        tmp_ff        <= cmd_sh_ff[7:0];
        pb_pend_ff    <= 1'b1;
        pb_hi_ff      <= fill_high_ff;
        fill_high_ff  <= ~fill_high_ff;
        fill_first_ff <= 1'b0;
        step_ff       <= ~fill_high_ff & ~fill_first_ff;
      end
      else if (sel_dump && state_ff == cap_dr && prog_ff)
      begin
        dump_high_ff <= ~dump_high_ff;
        step_ff      <= dump_high_ff;
      end
    end
  end

  // one execute clock on each entry to run-test/idle while the command instruction is selected in programming mode
  always_ff @(posedge tck or posedge rst)
  begin
    if (rst)
      exec_ff <= 1'b0;
    else
      exec_ff <= sel_cmd && prog_ff && state_ff == rti && prev_ff != rti;
  end

  // flash request, pointer step comes in the same cycle as the byte write
  always_comb
  begin
    flash_req          = '0;
    flash_req.cmd      = cmd_ff;
    flash_req.exec     = exec_ff;
    flash_req.pb_write = pb_pend_ff;
    flash_req.pb_high  = pb_hi_ff;
    flash_req.pb_data  = tmp_ff;
    flash_req.pc_step  = step_ff;
  end

  // tdo on falling edge, lsb of the selected path
  logic tdo_ff;
  logic oe_ff;

  always_ff @(negedge tck or posedge rst)
  begin
    if (rst)
    begin
      tdo_ff <= 1'b0;
      oe_ff  <= 1'b0;
    end
    else
    begin
      oe_ff <= state_ff == sh_dr || state_ff == sh_ir;
      if (state_ff == sh_ir)
        tdo_ff <= ir_sh_ff[0];
      else if (sel_chain)
        tdo_ff <= chain_ff;
      else if (sel_unlock)
        tdo_ff <= unlock_ff[0];
      else if (sel_cmd || sel_fill || sel_dump)
        tdo_ff <= cmd_sh_ff[0];
      else
        tdo_ff <= bypass_ff;
    end
  end
  assign tdo_o  = tdo_ff;
  assign tdo_oe = oe_ff;

  // reset time-out after chain release, chip clock domain
  logic        ch_meta_ff;
  logic        ch_sync_ff;
  logic [15:0] to_cnt_ff;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ch_meta_ff <= 1'b0;
      ch_sync_ff <= 1'b0;
      to_cnt_ff  <= 16'h0000;
    end
    else
    begin
      ch_meta_ff <= chain_ff;
      ch_sync_ff <= ch_meta_ff;
      if (ch_sync_ff)
        to_cnt_ff <= 16'(RST_TIMEOUT);
      else if (to_cnt_ff != 16'h0000)
        to_cnt_ff <= to_cnt_ff - 16'h0001;
    end
  end
  // chain bit acts at once, time-out holds afterwards
  assign chip_reset = chain_ff | ch_sync_ff | (to_cnt_ff != 16'h0000);

  // serial programming decoder on chip clock
  logic [2:0]  sck_ff;
  logic        mosi_meta_ff;
  logic        mosi_ff;
  logic [4:0]  bit_cnt_ff;
  logic [15:0] ser_in_ff;
  logic [7:0]  ser_out_ff;
  logic        miso_ff;
  logic [7:0]  ser_reply;

  always_comb
  begin
    ser_reply = 8'h00;
    if (ser_in_ff[15:8] == `SER_POLL_B1 && ser_in_ff[7:0] == `SER_POLL_B2)
      ser_reply = {7'h00, op_in_progress};
    else if (ser_in_ff[15:8] == `SER_EFUSE_B1 && ser_in_ff[7:0] == `SER_EFUSE_B2)
      ser_reply = ext_fuse;
    else if (ser_in_ff[15:8] == `SER_CAL_B1)
      ser_reply = cal_byte;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sck_ff       <= 3'h0;
      mosi_meta_ff <= 1'b0;
      mosi_ff      <= 1'b0;
    end
    else
    begin
      sck_ff       <= {sck_ff[1:0], sck};
      mosi_meta_ff <= mosi;
      mosi_ff      <= mosi_meta_ff;
    end
  end

  // msb-first frame, reply shifted out in the fourth byte
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      bit_cnt_ff <= 5'h00;
      ser_in_ff  <= 16'h0000;
      ser_out_ff <= 8'h00;
      miso_ff    <= 1'b0;
    end
    else if (!ext_rst_low_ff)
      bit_cnt_ff <= 5'h00;
    else if (sck_ff[1] && !sck_ff[2])
    begin
      bit_cnt_ff <= bit_cnt_ff + 5'h01;
      if (bit_cnt_ff < 5'd16)
        ser_in_ff <= {ser_in_ff[14:0], mosi_ff};
      if (bit_cnt_ff == `SER_OUT_BIT - 5'h01)
        ser_out_ff <= ser_reply;
    end
    else if (!sck_ff[1] && sck_ff[2] && bit_cnt_ff >= `SER_OUT_BIT)
    begin
      miso_ff    <= ser_out_ff[7];
      ser_out_ff <= {ser_out_ff[6:0], 1'b0};
    end
  end
  assign miso_o  = miso_ff;
  assign miso_oe = ext_rst_low_ff && bit_cnt_ff >= `SER_OUT_BIT;

  // checks on the test clock, except the port clear check on the chip clock
  a_unlock_exact_match: assert property (@(posedge tck) disable iff (rst)
    (sel_unlock && state_ff == upd_dr) |=> (prog_ff == ($past(unlock_ff) == `UNLOCK_KEY)))
    else $error("programming mode does not follow key match");
  a_wrong_key_off: assert property (@(posedge tck) disable iff (rst)
    (sel_unlock && state_ff == upd_dr && unlock_ff != `UNLOCK_KEY) |=> !prog_ff ##1 !pb_pend_ff)
    else $error("wrong key left programming enabled");
  a_exec_once: assert property (@(posedge tck) disable iff (rst)
    exec_ff |=> !exec_ff)
    else $error("execute pulse longer than one cycle");
  a_exec_cause: assert property (@(posedge tck) disable iff (rst)
    $rose(state_ff == rti) && sel_cmd && prog_ff |=> exec_ff)
    else $error("no execute pulse on idle entry");
  a_fill_within: assert property (@(posedge tck) disable iff (rst)
    (sel_fill && state_ff == upd_dr && prog_ff) |-> ##[1:11] pb_pend_ff)
    else $error("page byte not written in time");
  a_fill_alternate: assert property (@(posedge tck) disable iff (rst)
    (sel_fill && state_ff == upd_dr && prog_ff) |=> fill_high_ff != $past(fill_high_ff))
    else $error("page load byte half did not alternate");
  a_dump_step: assert property (@(posedge tck) disable iff (rst)
    (sel_dump && state_ff == cap_dr && prog_ff && dump_high_ff) |=> step_ff)
    else $error("no pointer step after high byte read");
  a_chain_reset: assert property (@(posedge tck) disable iff (rst)
    chain_ff |-> chip_reset)
    else $error("reset chain one without chip reset");
  a_port_clear: assert property (@(posedge ref_clk) disable iff (rst)
    ext_rst_low_ff [*3] |-> !disable_ff)
    else $error("disable bit not cleared by external reset");
endmodule : prog_port
`default_nettype wire

// [tb/prog_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
// external programmer on the four test pins only
module prog_host_model #(
  parameter int HALF_NS = 3  // test clock rate in one place
)(
  // test pins driven by the programmer
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  // test data back from the device
  input  wire logic tdo_o
);
  // clock stands still low outside frames
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // one test clock, pins changed while clock is low
  task automatic tick(input logic ms, input logic di, output logic dout);
  begin
    tms = ms;
    tdi = di;
    #HALF_NS tck = 1'b1;
    dout = tdo_o;
    #HALF_NS tck = 1'b0;
  end
  endtask : tick

  // walk to test-logic-reset, then rest in run-test/idle
  task automatic reset_tap;
    logic d;
  begin
    repeat (6) tick(1'b1, 1'b0, d);
    repeat (3) tick(1'b0, 1'b0, d);
  end
  endtask : reset_tap

  // ir or dr scan from idle, back to idle with spare idle clocks
  task automatic scan(input logic is_ir, input int n, input logic [15:0] din,
                      output logic [15:0] dout);
    logic d;
  begin
    dout = '0;
    tick(1'b1, 1'b0, d);
    if (is_ir)
      tick(1'b1, 1'b0, d);
    tick(1'b0, 1'b0, d);
    tick(1'b0, 1'b0, d);
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, din[i], d);  // lsb first
      dout[i] = d;
    end
    tick(1'b1, ~din[n-1], d);
    repeat (3) tick(1'b0, ~din[n-1], d);
  end
  endtask : scan
endmodule : prog_host_model
`default_nettype wire

// [tb/test_jtag_memory_programming_port.sv]
`timescale 1ns/100ps
`default_nettype none
`include "prog_port_regs.svh"
module test_jtag_memory_programming_port
  import prog_port_pkg::*;
;
  logic        ref_clk, rst, tck, tms, tdi, tdo_o, tdo_oe;
  logic        ext_reset_n, port_enable_fuse, port_disable_set, port_disable_bit;
  logic        chip_reset, prog_mode, op_in_progress, sck, mosi, miso_o, miso_oe;
  flash_req_s  flash_req;
  logic [14:0] flash_result;
  logic [15:0] flash_word, d;
  logic [7:0]  ext_fuse, cal_byte, r;
  int          n_fail, check_count, n_exec, n_step, seen_oe;
  logic [8:0]  wq[$];

  prog_port #(.RST_TIMEOUT(2)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo_o(tdo_o), .tdo_oe(tdo_oe), .ext_reset_n(ext_reset_n),
    .port_enable_fuse(port_enable_fuse), .port_disable_set(port_disable_set),
    .port_disable_bit(port_disable_bit), .chip_reset(chip_reset),
    .prog_mode(prog_mode), .flash_req(flash_req), .flash_result(flash_result),
    .flash_word(flash_word), .op_in_progress(op_in_progress), .sck(sck),
    .mosi(mosi), .ext_fuse(ext_fuse), .cal_byte(cal_byte), .miso_o(miso_o),
    .miso_oe(miso_oe));

  prog_host_model u_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o));

  // chip clock
  always #50 ref_clk = ~ref_clk;

  // tally flash pulses and output enable on the test clock
  always @(posedge tck)
  begin
    if (flash_req.exec === 1'b1) n_exec++;
    if (flash_req.pc_step === 1'b1) n_step++;
    if (flash_req.pb_write === 1'b1) wq.push_back({flash_req.pb_high, flash_req.pb_data});
    if (tdo_oe === 1'b1) seen_oe++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
  begin
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  end
  endtask : chk

  task automatic finish_test;
  begin
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask : finish_test

  // idle values and instruction capture pattern
  task automatic t_reset;
  begin
    chk(32'(prog_mode), 0, "prog mode at reset");
    chk(32'(flash_req), 0, "flash request at reset");
    u_host.scan(1'b1, 4, 16'(`IR_BYPASS), d);
    chk(32'(d[3:0]), `IR_CAPTURE_VAL, "ir capture");
    $display("test reset done");
  end
  endtask : t_reset

  // chip into reset, then wrong and right key
  task automatic t_unlock;
  begin
    u_host.scan(1'b1, 4, 16'(`IR_RESET_CHAIN), d);
    u_host.scan(1'b0, 1, 16'h0001, d);
    chk(32'(chip_reset), 1, "chain holds reset");
    u_host.scan(1'b1, 4, 16'(`IR_UNLOCK), d);
    u_host.scan(1'b0, 16, `UNLOCK_KEY ^ 16'h8000, d);
    chk(32'(prog_mode), 0, "wrong key");
    u_host.scan(1'b0, 16, `UNLOCK_KEY, d);
    chk(32'(prog_mode), 1, "right key");
    $display("test unlock done");
  end
  endtask : t_unlock

  // command result out, command applied, one execute per idle visit
  task automatic t_command;
    int e0;
  begin
    flash_result = 15'h2a5c;
    u_host.scan(1'b1, 4, 16'(`IR_COMMAND), d);
    e0 = n_exec;
    u_host.scan(1'b0, 15, 16'h1234, d);
    chk(32'(d[14:0]), 32'h2a5c, "command result");
    chk(32'(flash_req.cmd), 32'h1234, "applied command");
    chk(n_exec - e0, 1, "execute pulses");
    $display("test command done");
  end
  endtask : t_command

  // four page bytes: low/high alternation, pointer steps once
  task automatic t_fill;
    logic [7:0] b[4];
    int         s0;
  begin
    b = '{8'h11, 8'h22, 8'h33, 8'h44};
    u_host.scan(1'b1, 4, 16'(`IR_PAGE_FILL), d);
    wq.delete();
    s0 = n_step;
    for (int k = 0; k < 4; k++)
      u_host.scan(1'b0, 8, 16'(b[k]), d);
    chk(wq.size(), 4, "page writes");
    for (int k = 0; k < 4 && k < wq.size(); k++)
      chk(32'(wq[k]), 32'({k[0], b[k]}), "page write byte");
    chk(n_step - s0, 1, "fill pointer steps");
    $display("test fill done");
  end
  endtask : t_fill

  // four byte reads: low then high, pointer steps after each high
  task automatic t_dump;
    int s0;
  begin
    flash_word = 16'hbeef;
    u_host.scan(1'b1, 4, 16'(`IR_PAGE_DUMP), d);
    s0 = n_step;
    for (int k = 0; k < 4; k++)
    begin
      u_host.scan(1'b0, 8, 16'h0000, d);
      chk(32'(d[7:0]), k[0] ? 32'hbe : 32'hef, "page read byte");
    end
    chk(n_step - s0, 2, "dump pointer steps");
    $display("test dump done");
  end
  endtask : t_dump

  // clear key on leaving, release chain, watch the time-out
  task automatic t_leave;
  begin
    u_host.scan(1'b1, 4, 16'(`IR_UNLOCK), d);
    u_host.scan(1'b0, 16, `UNLOCK_RESET, d);
    chk(32'(prog_mode), 0, "key cleared");
    u_host.scan(1'b1, 4, 16'(`IR_RESET_CHAIN), d);
    u_host.scan(1'b0, 1, 16'h0000, d);
    repeat (2) @(negedge ref_clk);
    chk(32'(chip_reset), 1, "time-out running");
    repeat (10) @(negedge ref_clk);
    chk(32'(chip_reset), 0, "time-out over");
    $display("test leave done");
  end
  endtask : t_leave

  // disable bit refuses the port, external reset clears it
  task automatic t_disable;
  begin
    @(negedge ref_clk) port_disable_set = 1'b1;
    @(negedge ref_clk) port_disable_set = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk(32'(port_disable_bit), 1, "disable set");
    seen_oe = 0;
    u_host.scan(1'b1, 4, 16'(`IR_BYPASS), d);
    chk(seen_oe, 0, "port refused");
    @(negedge ref_clk) ext_reset_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk(32'(port_disable_bit), 0, "disable cleared");
    ext_reset_n = 1'b1;
    u_host.reset_tap();
    u_host.scan(1'b1, 4, 16'(`IR_BYPASS), d);
    chk(32'(d[3:0]), `IR_CAPTURE_VAL, "port back");
    $display("test disable done");
  end
  endtask : t_disable

  // one 32 bit serial frame msb first, reply from the last byte
  task automatic ser(input logic [31:0] w, output logic [7:0] rb);
  begin
    for (int i = 31; i >= 0; i--)
    begin
      @(negedge ref_clk);
      sck = 1'b0;
      mosi = w[i];
      repeat (4) @(negedge ref_clk);
      if (i < 8) rb[i] = miso_o;
      sck = 1'b1;
      repeat (3) @(negedge ref_clk);
    end
    @(negedge ref_clk) sck = 1'b0;
  end
  endtask : ser

  // busy poll, extended fuse, calibration and an unknown command
  task automatic t_serial;
  begin
    @(negedge ref_clk) ext_reset_n = 1'b0;
    op_in_progress = 1'b1;
    ser({`SER_POLL_B1, `SER_POLL_B2, 16'h0000}, r);
    chk(32'(r), 32'h01, "busy poll");
    op_in_progress = 1'b0;
    ser({`SER_POLL_B1, `SER_POLL_B2, 16'h0000}, r);
    chk(32'(r), 32'h00, "idle poll");
    ser({`SER_EFUSE_B1, `SER_EFUSE_B2, 16'h0000}, r);
    chk(32'(r), 32'(ext_fuse), "extended fuse");
    ser({`SER_CAL_B1, 24'h000000}, r);
    chk(32'(r), 32'(cal_byte), "calibration");
    ser(32'h55000000, r);
    chk(32'(r), 32'h00, "unknown command");
    chk(32'(miso_oe), 0, "miso released after frame");
    ext_reset_n = 1'b1;
    $display("test serial done");
  end
  endtask : t_serial

  // watchdog
  initial
  begin
    #5000000;
    n_fail++;
    $display("ERROR %0t watchdog expired", $time);
    finish_test();
  end

  // main sequence
  initial
  begin
    ref_clk = 1'b0;
    rst = 1'b1;
    ext_reset_n = 1'b1;
    port_enable_fuse = 1'b1;
    port_disable_set = 1'b0;
    flash_result = '0;
    flash_word = '0;
    op_in_progress = 1'b0;
    sck = 1'b0;
    mosi = 1'b0;
    ext_fuse = 8'ha5;
    cal_byte = 8'h3c;
    n_fail = 0;
    check_count = 0;
    n_exec = 0;
    n_step = 0;
    seen_oe = 0;
    u_host.reset_tap();
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    u_host.reset_tap();
    t_reset();
    t_unlock();
    t_command();
    t_fill();
    t_dump();
    t_leave();
    t_disable();
    t_serial();
    finish_test();
  end
endmodule : test_jtag_memory_programming_port
`default_nettype wire
